// ===== rtl/acq_map.svh
`ifndef ACQ_MAP_SVH
`define ACQ_MAP_SVH

// Register offsets
`define REG_MODE 8'h00
`define REG_LAMP 8'h04
`define REG_INTEG_MS 8'h08
`define REG_SS_ASSERT 8'h0c
`define REG_SS_CLEAR 8'h10
`define REG_CS_PERIOD 8'h14
`define REG_REQUEST 8'h18
`define REG_STATUS 8'h1c
`define REG_IFACE 8'h20
`define REG_TEC_SETPOINT 8'h24

// Pixel layout
`define PIX_TOTAL 1044
`define PIX_ACTIVE 1024
`define PIX_BLANK 10
`define USB_WORDS 1280
`define BUF_SLOTS 3

// Integration limits, milliseconds
`define INTEG_MIN_MS 32'd8
`define INTEG_MAX_MS 32'd1600000
`define INTEG_COARSE_MS 32'd655000
`define INTEG_COARSE_STEP 5'd25
`define INTEG_RST_MS 32'd100

// Timing
`define CLK_PERIOD_NS 20
`define NS_PER_MS 1000000
`define CYC_PER_MS (`NS_PER_MS / `CLK_PERIOD_NS)
`define STEP_NS 500
`define CYC_PER_STEP (`STEP_NS / `CLK_PERIOD_NS)
`define SS_DELAY_MAX_NS 30000000
`define SS_DELAY_MAX_STEPS (`SS_DELAY_MAX_NS / `STEP_NS)
`define CS_MIN_US 32'd2
`define CS_MAX_US 32'd60000000
`define CS_RST_US 26'd1000

// Reset values and lamp codes
`define TEC_SETPOINT_RST 16'hfff6
`define LAMP_OFF 32'h0
`define LAMP_ON 32'h1

`endif

// ===== rtl/acq_pkg.sv
package acq_pkg;

    typedef enum logic [1:0] {
        MODE_FREE = 2'h0,
        MODE_SYNC = 2'h1,
        MODE_LEVEL = 2'h2,
        MODE_EDGE = 2'h3
    } mode_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_INTEG = 1'b1
    } acq_state_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } sensor_pix_t;

    typedef struct packed {
        logic last;
        logic [15:0] data;
    } host_word_t;

endpackage

// ===== rtl/spectrum_acquisition_sequencer.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`include "acq_map.svh"
module spectrum_acquisition_sequencer #(
    parameter int unsigned CYC_PER_MS = `CYC_PER_MS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic trigger_in,
    input wire acq_pkg::sensor_pix_t sensor_pix,
    output logic vertical_transfer_clock,
    output logic readout_start,
    output logic out_valid,
    output acq_pkg::host_word_t out_word,
    input wire logic out_ready,
    output logic lamp_enable,
    output logic single_strobe,
    output logic continuous_strobe,
    output logic [15:0] tec_setpoint
);
    localparam logic [10:0] PIX_LAST = 11'(`PIX_TOTAL - 1);
    localparam logic [10:0] USB_LAST = 11'(`USB_WORDS - 1);
    localparam logic [10:0] BLANK = 11'(`PIX_BLANK);
    localparam logic [10:0] TOTAL = 11'(`PIX_TOTAL);
    localparam logic [15:0] MS_LAST = 16'(CYC_PER_MS - 1);
    localparam logic [4:0] STEP_LAST = 5'(`CYC_PER_STEP - 1);
    localparam logic [16:0] SS_MAX = 17'(`SS_DELAY_MAX_STEPS);

    // Three spectrum slots in one flat array
    logic [15:0] mem [0:`BUF_SLOTS*`PIX_TOTAL-1];

    acq_pkg::mode_t mode_reg;
    acq_pkg::acq_state_t state_reg;
    logic [31:0] integ_ms_reg;
    logic [16:0] ss_assert_reg, ss_clear_reg;
    logic [25:0] cs_period_reg;
    logic iface_rs232_reg;
    logic halted_reg, armed_reg;
    logic [1:0] req_cnt_reg, count_reg, wr_slot_reg, rd_slot_reg;
    logic trig_meta, trig_sync, trig_d;
    logic [15:0] cyc_cnt_reg;
    logic [20:0] elapsed_reg;
    logic [4:0] sub25_reg;
    logic cap_active_reg;
    logic [10:0] cap_idx_reg;
    logic streaming_reg, more_reg, rs_sel_reg;
    logic [10:0] k_reg;
    logic [4:0] step_cnt_reg, ss_sub_reg;
    logic [16:0] ss_cnt_reg;
    logic ss_run_reg;
    logic [26:0] cs_cnt_reg;

    // Synchroniser; only trig_sync and its delayed copy trig_d feed logic
    always_ff @(posedge clk) begin
        if (!resetn) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_d <= 1'b0;
        end else begin
            trig_meta <= trigger_in;
            trig_sync <= trig_meta;
            trig_d <= trig_sync;
        end
    end
    wire trig_rise = trig_sync & ~trig_d;

    // Register decode
    wire wr_mode = reg_wr && reg_addr == `REG_MODE;
    wire wr_lamp = reg_wr && reg_addr == `REG_LAMP;
    wire wr_integ = reg_wr && reg_addr == `REG_INTEG_MS;
    wire wr_ss_a = reg_wr && reg_addr == `REG_SS_ASSERT;
    wire wr_ss_c = reg_wr && reg_addr == `REG_SS_CLEAR;
    wire wr_cs = reg_wr && reg_addr == `REG_CS_PERIOD;
    wire wr_req = reg_wr && reg_addr == `REG_REQUEST;
    wire wr_iface = reg_wr && reg_addr == `REG_IFACE;
    wire wr_tec = reg_wr && reg_addr == `REG_TEC_SETPOINT;
    wire integ_ok = reg_wdata >= `INTEG_MIN_MS && reg_wdata <= `INTEG_MAX_MS;
    wire ss_ok = reg_wdata <= 32'(SS_MAX);
    wire cs_ok = reg_wdata >= `CS_MIN_US && reg_wdata <= `CS_MAX_US;

    // Integration timing in 1 ms ticks, 25 ms granularity above the coarse bound
    wire ms_tick = cyc_cnt_reg == MS_LAST;
    wire [20:0] elapsed_next = elapsed_reg + 21'h1;
    wire fine = integ_ms_reg < `INTEG_COARSE_MS;
    wire sub_wrap = sub25_reg == `INTEG_COARSE_STEP - 5'h1;
    wire time_done = ms_tick && 32'(elapsed_next) >= integ_ms_reg && (fine || sub_wrap);

    // Buffer events
    wire cap_take = cap_active_reg & sensor_pix.valid;
    wire push = cap_take && cap_idx_reg == PIX_LAST;
    wire overflow = push && count_reg == 2'h3;
    wire out_take = out_valid & out_ready;
    wire pop_done = streaming_reg & out_take & out_word.last;

    // Acquisition sequencing
    logic start_acq, end_acq, cont_acq;
    always_comb begin
        unique case (mode_reg)
            acq_pkg::MODE_FREE: start_acq = !halted_reg;
            acq_pkg::MODE_SYNC: start_acq = !halted_reg && trig_rise;
            acq_pkg::MODE_LEVEL: start_acq = !halted_reg && trig_rise;
            acq_pkg::MODE_EDGE: start_acq = armed_reg && trig_rise;
        endcase
        end_acq = (mode_reg == acq_pkg::MODE_SYNC) ? trig_rise : time_done;
        unique case (mode_reg)
            acq_pkg::MODE_FREE: cont_acq = 1'b1;
            acq_pkg::MODE_SYNC: cont_acq = 1'b1;
            acq_pkg::MODE_LEVEL: cont_acq = trig_sync;
            acq_pkg::MODE_EDGE: cont_acq = 1'b0;
        endcase
    end
    wire in_integ = state_reg == acq_pkg::ST_INTEG;
    wire finish = in_integ & end_acq & ~wr_mode;
    wire integ_start = ~wr_mode & ~overflow &
        ((~in_integ & start_acq) | (finish & cont_acq));

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= acq_pkg::ST_IDLE;
        end else if (wr_mode || overflow) begin
            state_reg <= acq_pkg::ST_IDLE;
        end else if (integ_start) begin
            state_reg <= acq_pkg::ST_INTEG;
        end else if (finish) begin
            state_reg <= acq_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || integ_start) begin
            cyc_cnt_reg <= 16'h0;
            elapsed_reg <= 21'h0;
            sub25_reg <= 5'h0;
        end else if (ms_tick) begin
            cyc_cnt_reg <= 16'h0;
            elapsed_reg <= elapsed_next;
            sub25_reg <= sub_wrap ? 5'h0 : sub25_reg + 5'h1;
        end else begin
            cyc_cnt_reg <= cyc_cnt_reg + 16'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            vertical_transfer_clock <= 1'b0;
            readout_start <= 1'b0;
        end else begin
            vertical_transfer_clock <= integ_start;
            readout_start <= finish;
        end
    end

    // Pixel capture in native order, one summed line
    always_ff @(posedge clk) begin
        if (!resetn || overflow) begin
            cap_active_reg <= 1'b0;
            cap_idx_reg <= 11'h0;
        end else if (finish) begin
            cap_active_reg <= 1'b1;
            cap_idx_reg <= 11'h0;
        end else if (cap_take) begin
            cap_idx_reg <= cap_idx_reg + 11'h1;
            if (cap_idx_reg == PIX_LAST) begin
                cap_active_reg <= 1'b0;
            end
        end
    end

    function automatic logic [11:0] slot_base(input logic [1:0] slot);
        unique case (slot)
            2'h1: slot_base = 12'(`PIX_TOTAL);
            2'h2: slot_base = 12'(2 * `PIX_TOTAL);
            default: slot_base = 12'h0;
        endcase
    endfunction

    function automatic logic [1:0] slot_inc(input logic [1:0] slot);
        slot_inc = (slot == 2'h2) ? 2'h0 : slot + 2'h1;
    endfunction

    wire [11:0] cap_addr = slot_base(wr_slot_reg) + {1'b0, cap_idx_reg};
    always_ff @(posedge clk) begin
        if (cap_take) begin
            mem[cap_addr] <= sensor_pix.data;
        end
    end

    // FIFO bookkeeping; the slot being sent stays counted until its last word
    always_ff @(posedge clk) begin
        if (!resetn || overflow) begin
            count_reg <= 2'h0;
            wr_slot_reg <= 2'h0;
            rd_slot_reg <= 2'h0;
        end else begin
            count_reg <= count_reg + 2'(push) - 2'(pop_done);
            if (push) begin
                wr_slot_reg <= slot_inc(wr_slot_reg);
            end
            if (pop_done) begin
                rd_slot_reg <= slot_inc(rd_slot_reg);
            end
        end
    end

    wire start_stream = ~streaming_reg && req_cnt_reg != 2'h0 && count_reg != 2'h0 && ~overflow;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            halted_reg <= 1'b1;
            armed_reg <= 1'b0;
            req_cnt_reg <= 2'h0;
        end else begin
            // A flush in the same cycle as a request still halts
            halted_reg <= overflow ? 1'b1 : (wr_req ? 1'b0 : halted_reg);
            if (wr_req) begin
                armed_reg <= 1'b1;
            end else if (~in_integ && start_acq && mode_reg == acq_pkg::MODE_EDGE) begin
                armed_reg <= 1'b0;
            end
            if (wr_req && !start_stream && req_cnt_reg != 2'h3) begin
                req_cnt_reg <= req_cnt_reg + 2'h1;
            end else if (!wr_req && start_stream) begin
                req_cnt_reg <= req_cnt_reg - 2'h1;
            end
        end
    end

    // Host word ordering
    wire [10:0] limit = rs_sel_reg ? PIX_LAST : USB_LAST;
    wire [10:0] rs_idx = (k_reg + BLANK < TOTAL) ? k_reg + BLANK : k_reg + BLANK - TOTAL;
    wire usb_pad = k_reg > PIX_LAST;
    wire [10:0] src_idx = rs_sel_reg ? rs_idx : k_reg;
    wire [11:0] rd_addr = slot_base(rd_slot_reg) + {1'b0, src_idx};
    wire [15:0] src_word = (!rs_sel_reg && usb_pad) ? 16'h0 : mem[rd_addr];
    wire load = streaming_reg & more_reg & (~out_valid | out_ready);

    always_ff @(posedge clk) begin
        if (!resetn || overflow) begin
            streaming_reg <= 1'b0;
            more_reg <= 1'b0;
            out_valid <= 1'b0;
            out_word <= '0;
            k_reg <= 11'h0;
            rs_sel_reg <= 1'b0;
        end else if (start_stream) begin
            streaming_reg <= 1'b1;
            more_reg <= 1'b1;
            k_reg <= 11'h0;
            rs_sel_reg <= iface_rs232_reg;
        end else begin
            if (load) begin
                out_valid <= 1'b1;
                out_word.data <= src_word;
                out_word.last <= k_reg == limit;
                k_reg <= k_reg + 11'h1;
                more_reg <= k_reg != limit;
            end else if (out_take) begin
                out_valid <= 1'b0;
            end
            if (pop_done) begin
                streaming_reg <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_reg <= acq_pkg::MODE_FREE;
            lamp_enable <= 1'b0;
            integ_ms_reg <= `INTEG_RST_MS;
            ss_assert_reg <= 17'h0;
            ss_clear_reg <= 17'h0;
            cs_period_reg <= `CS_RST_US;
            iface_rs232_reg <= 1'b0;
            tec_setpoint <= `TEC_SETPOINT_RST;
        end else begin
            if (wr_mode) begin
                mode_reg <= acq_pkg::mode_t'(reg_wdata[1:0]);
            end
            if (wr_lamp && reg_wdata == `LAMP_ON) begin
                lamp_enable <= 1'b1;
            end else if (wr_lamp && reg_wdata == `LAMP_OFF) begin
                lamp_enable <= 1'b0;
            end
            if (wr_integ && integ_ok) begin
                integ_ms_reg <= reg_wdata;
            end
            if (wr_ss_a && ss_ok) begin
                ss_assert_reg <= reg_wdata[16:0];
            end
            if (wr_ss_c && ss_ok) begin
                ss_clear_reg <= reg_wdata[16:0];
            end
            if (wr_cs && cs_ok) begin
                cs_period_reg <= reg_wdata[25:0];
            end
            if (wr_iface) begin
                iface_rs232_reg <= reg_wdata[0];
            end
            if (wr_tec) begin
                tec_setpoint <= reg_wdata[15:0];
            end
        end
    end

    // Register read, data one cycle after the strobe
    logic [31:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            `REG_MODE: rd_mux = {30'h0, mode_reg};
            `REG_LAMP: rd_mux = {31'h0, lamp_enable};
            `REG_INTEG_MS: rd_mux = integ_ms_reg;
            `REG_SS_ASSERT: rd_mux = {15'h0, ss_assert_reg};
            `REG_SS_CLEAR: rd_mux = {15'h0, ss_clear_reg};
            `REG_CS_PERIOD: rd_mux = {6'h0, cs_period_reg};
            `REG_STATUS: rd_mux = {24'h0, streaming_reg, armed_reg, req_cnt_reg,
                                   halted_reg, in_integ, count_reg};
            `REG_IFACE: rd_mux = {31'h0, iface_rs232_reg};
            `REG_TEC_SETPOINT: rd_mux = {16'h0, tec_setpoint};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // 500 ns step base for the continuous strobe
    wire step_tick = step_cnt_reg == STEP_LAST;
    always_ff @(posedge clk) begin
        if (!resetn || step_tick) begin
            step_cnt_reg <= 5'h0;
        end else begin
            step_cnt_reg <= step_cnt_reg + 5'h1;
        end
    end

    // Single strobe; own step phase so the delay is counted from the event itself.
    // In sync and edge modes integ_start is the cycle of the synchronised edge; level mode repeats it at time_done.
    wire ss_step = ss_sub_reg == STEP_LAST;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ss_run_reg <= 1'b0;
            ss_cnt_reg <= 17'h0;
            ss_sub_reg <= 5'h0;
        end else if (integ_start) begin
            ss_run_reg <= 1'b1;
            ss_cnt_reg <= 17'h0;
            ss_sub_reg <= 5'h0;
        end else if (ss_run_reg) begin
            ss_sub_reg <= ss_step ? 5'h0 : ss_sub_reg + 5'h1;
            if (ss_step) begin
                ss_cnt_reg <= ss_cnt_reg + 17'h1;
                if (ss_cnt_reg + 17'h1 >= ss_clear_reg) begin
                    ss_run_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            single_strobe <= 1'b0;
        end else begin
            single_strobe <= lamp_enable & ss_run_reg & ~integ_start &
                (ss_cnt_reg >= ss_assert_reg) & (ss_cnt_reg < ss_clear_reg);
        end
    end

    // Continuous strobe in half-microsecond ticks: high for P, low for P
    wire [26:0] cs_half = {1'b0, cs_period_reg};
    wire [26:0] cs_full = {cs_period_reg, 1'b0};
    always_ff @(posedge clk) begin
        if (!resetn || !lamp_enable) begin
            cs_cnt_reg <= 27'h0;
            continuous_strobe <= 1'b0;
        end else begin
            if (step_tick) begin
                cs_cnt_reg <= (cs_cnt_reg + 27'h1 >= cs_full) ? 27'h0 : cs_cnt_reg + 27'h1;
            end
            continuous_strobe <= cs_cnt_reg < cs_half;
        end
    end
endmodule

// ===== test/acq_chk.sv
`timescale 1ns/1ns
`include "acq_map.svh"
module acq_chk #(
    parameter int unsigned CYC_PER_MS = 50
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic trigger_in,
    input wire logic vertical_transfer_clock,
    input wire logic readout_start,
    input wire logic out_valid,
    input wire acq_pkg::host_word_t out_word,
    input wire logic out_ready,
    input wire logic lamp_enable,
    input wire logic single_strobe,
    input wire logic continuous_strobe,
    input wire logic [15:0] tec_setpoint
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Both strobes lag lamp by one register stage
    chk_ss_gated: assert property (!lamp_enable && !$past(lamp_enable) |-> !single_strobe)
        else $error("single strobe while lamp off");
    chk_cs_gated: assert property (!lamp_enable && !$past(lamp_enable) |-> !continuous_strobe)
        else $error("continuous strobe while lamp off");
    chk_reset_state: assert property ($rose(resetn) |-> !out_valid && !lamp_enable
        && !single_strobe && !continuous_strobe && tec_setpoint == 16'hfff6)
        else $error("outputs not at reset state");
    chk_tec_hold: assert property (!(reg_wr && reg_addr == `REG_TEC_SETPOINT)
        |=> $stable(tec_setpoint))
        else $error("set-point moved without write");
    chk_word_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
        else $error("word dropped while stalled");
    chk_gap_last: assert property (out_valid && out_ready && out_word.last |=> !out_valid)
        else $error("no gap after last word");
    chk_min_integ: assert property (vertical_transfer_clock
        |=> (!vertical_transfer_clock && !readout_start) [*8])
        else $error("integration far too short");
    chk_trig_sync: assert property ($rose(trigger_in)
        |-> !vertical_transfer_clock ##1 !vertical_transfer_clock)
        else $error("trigger used before synchroniser");
    chk_cs_run: assert property ($rose(continuous_strobe)
        |=> (continuous_strobe || !lamp_enable) [*8])
        else $error("continuous strobe high phase too short");
endmodule

bind spectrum_acquisition_sequencer acq_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .trigger_in(trigger_in),
    .vertical_transfer_clock(vertical_transfer_clock), .readout_start(readout_start),
    .out_valid(out_valid), .out_word(out_word), .out_ready(out_ready),
    .lamp_enable(lamp_enable), .single_strobe(single_strobe),
    .continuous_strobe(continuous_strobe), .tec_setpoint(tec_setpoint)
);

// ===== test/sensor_model.sv
`timescale 1ns/1ns
module sensor_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic readout_start,
    input wire logic slow,
    output acq_pkg::sensor_pix_t sensor_pix
);
    logic [10:0] idx_reg;
    logic run_reg;
    logic tick_reg;
    // One summed line in native order 0..1043; value tags its position
    always @(posedge clk) begin
        tick_reg <= resetn ? ~tick_reg : 1'b0;
        if (!resetn) begin
            run_reg <= 1'b0;
            idx_reg <= 11'h0;
            sensor_pix <= '0;
        end else if (run_reg && (!slow || tick_reg)) begin
            sensor_pix <= {1'b1, 5'h14, idx_reg};
            idx_reg <= idx_reg + 11'h1;
            run_reg <= (idx_reg != 11'd1043);
        end else begin
            // Idle data flips so a stale sample never looks right
            sensor_pix.valid <= 1'b0;
            sensor_pix.data <= ~sensor_pix.data;
            if (readout_start) begin
                run_reg <= 1'b1;
                idx_reg <= 11'h0;
            end
        end
    end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ns
`include "acq_map.svh"
module tb_top;
    logic clk = 0;
    logic resetn = 0;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic trigger_in = 0;
    logic slow = 0;
    logic out_ready = 0;
    logic [31:0] reg_rdata;
    acq_pkg::sensor_pix_t sensor_pix;
    acq_pkg::host_word_t out_word;
    logic vtc, ro, out_valid, lamp, ss, cs;
    logic [15:0] thermo_cooler;
    logic [31:0] d;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_vtc = 0;
    int n_ro = 0;
    int t0, t1, k;

    always #10 clk = ~clk;

    // Small ms count keeps integrations to a few thousand cycles
    spectrum_acquisition_sequencer #(.CYC_PER_MS(50)) uut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_in(trigger_in),
        .sensor_pix(sensor_pix), .vertical_transfer_clock(vtc), .readout_start(ro),
        .out_valid(out_valid), .out_word(out_word), .out_ready(out_ready),
        .lamp_enable(lamp), .single_strobe(ss), .continuous_strobe(cs), .tec_setpoint(thermo_cooler)
    );
    sensor_model partner (
        .clk(clk), .resetn(resetn), .readout_start(ro), .slow(slow), .sensor_pix(sensor_pix)
    );

    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_vtc <= n_vtc + int'(vtc === 1'b1);
        n_ro <= n_ro + int'(ro === 1'b1);
        if (cyc == 90000) begin
            failures++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Host side with periodic stalls; rs selects the serial ordering
    task automatic rcv(input int n, input bit rs);
        int w;
        int e;
        for (int i = 0; i < n; i++) begin
            w = 0;
            do begin
                out_ready <= (cyc % 5 != 0);
                @(posedge clk);
                w++;
            end while (!(out_valid === 1'b1 && out_ready === 1'b1) && w < 9000);
            e = rs ? (i < 1034 ? i + 10 : i - 1034) : i;
            e = (rs || i < 1044) ? 32'ha000 + e : 0;
            check(out_word.data, e);
            check(out_word.last, i == n - 1);
        end
        // Stall between receives so no word is taken unseen
        out_ready <= 1'b0;
    endtask

    task automatic pulse(input int hi, input int lo);
        trigger_in <= 1'b1;
        hold(hi);
        trigger_in <= 1'b0;
        hold(lo);
    endtask

    initial begin
        hold(8);
        resetn <= 1'b1;
        hold(1);
        check(thermo_cooler, 16'hfff6);
        check({lamp, ss, cs, out_valid}, 0);
        rd(`REG_STATUS, d);
        check(d & 32'hb, 32'h8);
        rd(8'h40, d);
        check(d, 0);
        rd(`REG_TEC_SETPOINT, d);
        check(d, 32'hfff6);
        hold(100 * 50);
        wr(`REG_TEC_SETPOINT, 32'hffec);
        hold(1);
        check(thermo_cooler, 16'hffec);
        rd(`REG_TEC_SETPOINT, d);
        check(d, 32'hffec);
        wr(`REG_INTEG_MS, 8);
        wr(`REG_INTEG_MS, 7);
        rd(`REG_INTEG_MS, d);
        check(d, 8);
        wr(`REG_INTEG_MS, 1600001);
        rd(`REG_INTEG_MS, d);
        check(d, 8);
        wr(`REG_INTEG_MS, 1600000);
        rd(`REG_INTEG_MS, d);
        check(d, 1600000);
        wr(`REG_INTEG_MS, 40);
        wr(`REG_LAMP, 1);
        wr(`REG_SS_ASSERT, 2);
        wr(`REG_SS_CLEAR, 5);
        wr(`REG_CS_PERIOD, 2);
        wr(`REG_IFACE, 0);
        wr(`REG_MODE, 0);
        wr(`REG_REQUEST, 1);
        for (int w = 0; w < 3000 && vtc !== 1'b1; w++) @(posedge clk);
        t0 = cyc;
        for (int w = 0; w < 3000 && ss !== 1'b1; w++) @(posedge clk);
        t1 = cyc;
        check((t1 - t0) inside {[48:53]}, 1);
        for (int w = 0; w < 3000 && ss !== 1'b0; w++) @(posedge clk);
        check(cyc - t1, 75);
        for (int w = 0; w < 3000 && ro !== 1'b1; w++) @(posedge clk);
        check((cyc - t0) inside {[1950:2051]}, 1);
        rcv(1280, 0);
        // Start on a true rising edge, not mid-phase
        for (int w = 0; w < 300 && cs !== 1'b0; w++) @(posedge clk);
        for (int w = 0; w < 300 && cs !== 1'b1; w++) @(posedge clk);
        t0 = cyc;
        for (int w = 0; w < 300 && cs !== 1'b0; w++) @(posedge clk);
        check(cyc - t0, 50);
        for (int w = 0; w < 300 && cs !== 1'b1; w++) @(posedge clk);
        check(cyc - t0, 100);
        wr(`REG_LAMP, 2);
        hold(1);
        check(lamp, 1);
        wr(`REG_LAMP, 0);
        hold(200);
        check({lamp, ss, cs}, 0);
        wr(`REG_IFACE, 1);
        wr(`REG_REQUEST, 1);
        rcv(1044, 1);
        d = 0;
        for (int w = 0; w < 200 && d[3] !== 1'b1; w++) begin
            hold(100);
            rd(`REG_STATUS, d);
        end
        check(d & 32'hb, 32'h8);
        k = n_vtc;
        hold(3000);
        check(n_vtc - k, 0);
        // Slow sensor here: pixel gaps must not upset the line
        slow <= 1'b1;
        wr(`REG_MODE, 1);
        wr(`REG_REQUEST, 1);
        k = n_ro;
        repeat (3) pulse(50, 2450);
        check(n_ro - k, 2);
        rcv(1044, 1);
        wr(`REG_MODE, 3);
        wr(`REG_REQUEST, 1);
        rcv(1044, 1);
        k = n_vtc;
        pulse(3000, 3000);
        check(n_vtc - k, 1);
        wr(`REG_MODE, 2);
        wr(`REG_REQUEST, 1);
        rcv(1044, 1);
        k = n_vtc;
        pulse(5000, 10);
        check(n_vtc - k >= 2, 1);
        conclude();
    end
endmodule
